// ### tpc_pkg.sv
// Package of register map, field layouts and reset values for probe capture.
`default_nettype none
package tpc_pkg;
   // Register word addresses on the Avalon-MM slave.
   localparam logic [3:0] TPC_ADDR_ENABLE = 4'h0;
   localparam logic [3:0] TPC_ADDR_REPEAT = 4'h1;
   localparam logic [3:0] TPC_ADDR_SOURCE = 4'h2;
   localparam logic [3:0] TPC_ADDR_EDGE = 4'h3;
   localparam logic [3:0] TPC_ADDR_STATUS = 4'h4;
   localparam logic [3:0] TPC_ADDR_CLEAR = 4'h5;
   localparam logic [3:0] TPC_ADDR_IRQ_EN = 4'h6;
   localparam logic [3:0] TPC_ADDR_COUNT = 4'h7;
   // Reset values of the settings.
   localparam logic [1:0] TPC_RST_ENABLE = 2'h0;
   localparam logic [1:0] TPC_RST_REPEAT = 2'h0;
   localparam logic [1:0] TPC_RST_SOURCE = 2'h0;
   localparam logic [3:0] TPC_RST_EDGE = 4'h0;
   // Edge mask field positions: rising and falling per channel.
   localparam int TPC_EDGE_CH1_RISE = 0;
   localparam int TPC_EDGE_CH1_FALL = 1;
   localparam int TPC_EDGE_CH2_RISE = 2;
   localparam int TPC_EDGE_CH2_FALL = 3;
   // Status bit positions: capture event of channel one and two.
   localparam int TPC_STAT_CH1 = 0;
   localparam int TPC_STAT_CH2 = 1;
   // Bus answer for unmapped reads.
   localparam logic [31:0] TPC_UNMAPPED_DATA = 32'h0000_0000;
endpackage : tpc_pkg
`default_nettype wire

// ### tpc_edge_det.sv
// Edge detector for one trigger line with a masked rising and falling pulse.
`default_nettype none
module tpc_edge_det
   import tpc_pkg::*;
(
   input wire logic sys_clk, // System clock.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic trig_in, // Trigger level.
   input wire logic rise_en, // Accept rising edges.
   input wire logic fall_en, // Accept falling edges.
   output logic edge_hit // One-cycle pulse on an accepted edge.
);
   logic prev_ff;
   logic nxt_prev;

   // Next value of the previous-level register.
   always_comb begin
      nxt_prev = trig_in;
   end

   // Registers the previous level, cleared at reset.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= nxt_prev;
      end
   end

   // Rising edges pass only when enabled, likewise falling ones.
   assign edge_hit = (rise_en & trig_in & ~prev_ff) |
                     (fall_en & ~trig_in & prev_ff);
endmodule // tpc_edge_det
`default_nettype wire

// ### tpc_channel.sv
// One capture channel: arming, single or continuous capture, event count.
`default_nettype none
module tpc_channel
   import tpc_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input wire logic sys_clk, // System clock.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic active, // Channel enabled by the enable setting.
   input wire logic rearm, // Pulse: enable setting was rewritten.
   input wire logic continuous, // Capture on every trigger when high.
   input wire logic edge_hit, // Qualified trigger edge.
   output logic capture, // One-cycle pulse when a capture is taken.
   output logic armed, // Channel is ready to capture.
   output logic [CNT_W-1:0] count // Number of captures taken.
);
   logic done_ff;
   logic nxt_done;
   logic [CNT_W-1:0] count_ff;
   logic [CNT_W-1:0] nxt_count;

   // A capture needs an active, armed channel and a qualified edge.
   assign armed = active & ~done_ff;
   assign capture = armed & edge_hit;

   // Single mode latches done after one capture until rearmed.
   always_comb begin
      nxt_done = done_ff;
      nxt_count = count_ff;
      if (rearm) begin
         nxt_done = 1'b0;
      end else if (capture && !continuous) begin
         nxt_done = 1'b1;
      end
      if (capture) begin
         nxt_count = count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // Registers the channel state.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         done_ff <= 1'b0;
         count_ff <= '0;
      end else begin
         done_ff <= nxt_done;
         count_ff <= nxt_count;
      end
   end

   assign count = count_ff;
endmodule // tpc_channel
`default_nettype wire

// ### tpc_capture_top.sv
// Top of the two-channel probe capture block with its Avalon-MM registers.
// How it works
// - Enable value 0 leaves both channels deaf; nothing is captured.
// - Enable 1 runs channel one only; enable 2 runs channel two only.
// - Enable 3 runs both channels, each on its own triggers.
// - Repeat mode 0 captures once on both; mode 3 captures always.
// - Mode 1: channel one continuous, two once; mode 2 the reverse.
// - Source 0: each channel triggers from its own probe pin.
// - Source 1: channel one uses index pulse, channel two its pin.
// - Source 2: channel two uses index; source 3 both use index.
// - Edge mask bit 0 enables channel one rising edges.
// - Edge mask bit 1 enables channel one falling edges.
// - Edge mask bit 2 enables channel two rising edges.
// - Edge mask bit 3 enables channel two falling edges.
// - Edge mask takes 0 to F; each set bit enables its edge.
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`default_nettype none
module tpc_capture_top
   import tpc_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input wire logic sys_clk, // System clock, 10 MHz.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic [3:0] avs_address, // Register word address.
   input wire logic avs_read, // Read request.
   input wire logic avs_write, // Write request.
   input wire logic [31:0] avs_writedata, // Write data.
   input wire logic [3:0] avs_byteenable, // Byte enables.
   output logic [31:0] avs_readdata, // Read data, registered.
   output logic avs_waitrequest, // Stall until answer is ready.
   input wire logic probe1_in, // Probe input of channel one.
   input wire logic probe2_in, // Probe input of channel two.
   input wire logic index_in, // Encoder index pulse.
   output logic capture1, // Capture pulse of channel one.
   output logic capture2, // Capture pulse of channel two.
   output logic irq // Level interrupt.
);
   logic [1:0] enable_ff;
   logic [1:0] nxt_enable;
   logic [1:0] repeat_ff;
   logic [1:0] nxt_repeat;
   logic [1:0] source_ff;
   logic [1:0] nxt_source;
   logic [3:0] edge_ff;
   logic [3:0] nxt_edge;
   logic [1:0] status_ff;
   logic [1:0] nxt_status;
   logic [1:0] irq_en_ff;
   logic [1:0] nxt_irq_en;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic ack_ff;
   logic nxt_ack;
   logic rearm;
   logic wr_ok;
   logic trig1;
   logic trig2;
   logic hit1;
   logic hit2;
   logic armed1;
   logic armed2;
   logic [CNT_W-1:0] count1;
   logic [CNT_W-1:0] count2;

   // Every access waits one cycle; the second cycle carries the answer.
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
   assign wr_ok = avs_write & ack_ff & avs_byteenable[0];
   assign rearm = wr_ok && (avs_address == TPC_ADDR_ENABLE);

   // Source select routes the probe pin or the index pulse to each channel.
   always_comb begin
      trig1 = probe1_in;
      trig2 = probe2_in;
      unique case (source_ff)
         2'h0: begin
            trig1 = probe1_in;
            trig2 = probe2_in;
         end
         2'h1: begin
            trig1 = index_in;
            trig2 = probe2_in;
         end
         2'h2: begin
            trig1 = probe1_in;
            trig2 = index_in;
         end
         2'h3: begin
            trig1 = index_in;
            trig2 = index_in;
         end
      endcase
   end

   // Edge qualification per channel, strictly bitwise over mask 0 to F.
   tpc_edge_det u_edge1 (
      .sys_clk(sys_clk),
      .rst(rst),
      .trig_in(trig1),
      .rise_en(edge_ff[TPC_EDGE_CH1_RISE]),
      .fall_en(edge_ff[TPC_EDGE_CH1_FALL]),
      .edge_hit(hit1)
   );
   tpc_edge_det u_edge2 (
      .sys_clk(sys_clk),
      .rst(rst),
      .trig_in(trig2),
      .rise_en(edge_ff[TPC_EDGE_CH2_RISE]),
      .fall_en(edge_ff[TPC_EDGE_CH2_FALL]),
      .edge_hit(hit2)
   );

   // Channel one: active on enable bit 0, continuous in modes 1 and 3.
   tpc_channel #(.CNT_W(CNT_W)) u_ch1 (
      .sys_clk(sys_clk),
      .rst(rst),
      .active(enable_ff[0]),
      .rearm(rearm),
      .continuous(repeat_ff[0]),
      .edge_hit(hit1),
      .capture(capture1),
      .armed(armed1),
      .count(count1)
   );
   // Channel two: active on enable bit 1, continuous in modes 2 and 3.
   tpc_channel #(.CNT_W(CNT_W)) u_ch2 (
      .sys_clk(sys_clk),
      .rst(rst),
      .active(enable_ff[1]),
      .rearm(rearm),
      .continuous(repeat_ff[1]),
      .edge_hit(hit2),
      .capture(capture2),
      .armed(armed2),
      .count(count2)
   );

   // Register writes, sticky status with set winning over clear.
   always_comb begin
      nxt_enable = enable_ff;
      nxt_repeat = repeat_ff;
      nxt_source = source_ff;
      nxt_edge = edge_ff;
      nxt_irq_en = irq_en_ff;
      nxt_status = status_ff;
      if (wr_ok) begin
         unique case (avs_address)
            TPC_ADDR_ENABLE: nxt_enable = avs_writedata[1:0];
            TPC_ADDR_REPEAT: nxt_repeat = avs_writedata[1:0];
            TPC_ADDR_SOURCE: nxt_source = avs_writedata[1:0];
            TPC_ADDR_EDGE: nxt_edge = avs_writedata[3:0];
            TPC_ADDR_CLEAR: nxt_status = status_ff & ~avs_writedata[1:0];
            TPC_ADDR_IRQ_EN: nxt_irq_en = avs_writedata[1:0];
            default: ;
         endcase
      end
      if (capture1) begin
         nxt_status[TPC_STAT_CH1] = 1'b1;
      end
      if (capture2) begin
         nxt_status[TPC_STAT_CH2] = 1'b1;
      end
   end

   // Read data mux, captured in the waiting cycle.
   always_comb begin
      nxt_ack = (avs_read | avs_write) & ~ack_ff;
      nxt_rdata = rdata_ff;
      if (avs_read && !ack_ff) begin
         unique case (avs_address)
            TPC_ADDR_ENABLE: nxt_rdata = {30'h0, enable_ff};
            TPC_ADDR_REPEAT: nxt_rdata = {30'h0, repeat_ff};
            TPC_ADDR_SOURCE: nxt_rdata = {30'h0, source_ff};
            TPC_ADDR_EDGE: nxt_rdata = {28'h0, edge_ff};
            TPC_ADDR_STATUS: nxt_rdata = {28'h0, armed2, armed1, status_ff};
            TPC_ADDR_IRQ_EN: nxt_rdata = {30'h0, irq_en_ff};
            TPC_ADDR_COUNT: nxt_rdata = {count2, count1};
            default: nxt_rdata = TPC_UNMAPPED_DATA;
         endcase
      end
   end

   // Registers all settings and bus state.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         enable_ff <= TPC_RST_ENABLE;
         repeat_ff <= TPC_RST_REPEAT;
         source_ff <= TPC_RST_SOURCE;
         edge_ff <= TPC_RST_EDGE;
         status_ff <= 2'h0;
         irq_en_ff <= 2'h0;
         rdata_ff <= 32'h0;
         ack_ff <= 1'b0;
      end else begin
         enable_ff <= nxt_enable;
         repeat_ff <= nxt_repeat;
         source_ff <= nxt_source;
         edge_ff <= nxt_edge;
         status_ff <= nxt_status;
         irq_en_ff <= nxt_irq_en;
         rdata_ff <= nxt_rdata;
         ack_ff <= nxt_ack;
      end
   end

   assign avs_readdata = rdata_ff;
   assign irq = |(status_ff & irq_en_ff);
endmodule // tpc_capture_top
`default_nettype wire

// ### tpc_capture_asserts.sv
// Concurrent checks on the ports of the probe capture block.
`default_nettype none
module tpc_capture_asserts
   import tpc_pkg::*;
(
   input wire logic sys_clk, // Clock.
   input wire logic rst, // Reset.
   input wire logic [3:0] avs_address, // Address.
   input wire logic avs_read, // Read.
   input wire logic avs_write, // Write.
   input wire logic [31:0] avs_writedata, // Write data.
   input wire logic [3:0] avs_byteenable, // Byte enables.
   input wire logic avs_waitrequest, // Stall.
   input wire logic probe1_in, // Probe one.
   input wire logic probe2_in, // Probe two.
   input wire logic index_in, // Index pulse.
   input wire logic capture1, // Capture one.
   input wire logic capture2, // Capture two.
   input wire logic irq // Interrupt.
);
   logic [1:0] en_ff, rep_ff, src_ff, ien_ff, nxt_en, nxt_rep, nxt_src;
   logic [1:0] nxt_ien;
   logic [3:0] edg_ff, nxt_edg;
   logic p1_ff, p2_ff, d1_ff, d2_ff, nxt_d1, nxt_d2;
   logic wok, t1, t2, q1, q2;
   // Selected triggers and qualified edges as the settings ask.
   assign wok = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign t1 = src_ff[0] ? index_in : probe1_in;
   assign t2 = src_ff[1] ? index_in : probe2_in;
   assign q1 = (t1 & ~p1_ff & edg_ff[0]) | (~t1 & p1_ff & edg_ff[1]);
   assign q2 = (t2 & ~p2_ff & edg_ff[2]) | (~t2 & p2_ff & edg_ff[3]);
   // Shadow settings and single-capture flags, updated on completed writes.
   always_comb begin
      {nxt_en, nxt_rep, nxt_src, nxt_ien} = {en_ff, rep_ff, src_ff, ien_ff};
      nxt_edg = edg_ff;
      nxt_d1 = d1_ff | (capture1 & ~rep_ff[0]);
      nxt_d2 = d2_ff | (capture2 & ~rep_ff[1]);
      if (wok && avs_address == TPC_ADDR_ENABLE) begin
         nxt_en = avs_writedata[1:0];
         nxt_d1 = 1'b0;
         nxt_d2 = 1'b0;
      end
      if (wok && avs_address == TPC_ADDR_REPEAT) nxt_rep = avs_writedata[1:0];
      if (wok && avs_address == TPC_ADDR_SOURCE) nxt_src = avs_writedata[1:0];
      if (wok && avs_address == TPC_ADDR_IRQ_EN) nxt_ien = avs_writedata[1:0];
      if (wok && avs_address == TPC_ADDR_EDGE) nxt_edg = avs_writedata[3:0];
   end
   // Registers of the shadow state; trigger history resets low.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         {en_ff, rep_ff, src_ff, ien_ff, edg_ff} <= '0;
         {p1_ff, p2_ff, d1_ff, d2_ff} <= '0;
      end else begin
         {en_ff, rep_ff, src_ff, ien_ff} <= {nxt_en, nxt_rep, nxt_src, nxt_ien};
         edg_ff <= nxt_edg;
         {p1_ff, p2_ff, d1_ff, d2_ff} <= {t1, t2, nxt_d1, nxt_d2};
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   property p_wait;
      s_req |=> !avs_waitrequest;
   endproperty
   property p_off;
      en_ff == 2'h0 |-> !capture1 && !capture2;
   endproperty
   property p_q1;
      capture1 |-> q1 && en_ff[0];
   endproperty
   property p_q2;
      capture2 |-> q2 && en_ff[1];
   endproperty
   property p_c1;
      q1 && en_ff[0] && rep_ff[0] |-> capture1;
   endproperty
   property p_c2;
      q2 && en_ff[1] && rep_ff[1] |-> capture2;
   endproperty
   property p_once;
      (d1_ff && !rep_ff[0] |-> !capture1) and (d2_ff && !rep_ff[1] |-> !capture2);
   endproperty
   property p_irq;
      capture1 && ien_ff[0] |=> irq;
   endproperty
   a_wait: assert property (p_wait) else $error("Bus answer late.");
   a_off: assert property (p_off) else $error("Capture while off.");
   a_q1: assert property (p_q1) else $error("Bad capture one.");
   a_q2: assert property (p_q2) else $error("Bad capture two.");
   a_c1: assert property (p_c1) else $error("Missed capture one.");
   a_c2: assert property (p_c2) else $error("Missed capture two.");
   a_once: assert property (p_once) else $error("Second capture.");
   a_irq: assert property (p_irq) else $error("Interrupt not raised.");
endmodule // tpc_capture_asserts
bind tpc_capture_top tpc_capture_asserts u_chk (.sys_clk, .rst, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
   .probe1_in, .probe2_in, .index_in, .capture1, .capture2, .irq);
`default_nettype wire

// ### tpc_probe_model.sv
// Behavioural model of the probe pins and the encoder index pulse.
`default_nettype none
module tpc_probe_model (
   input wire logic sys_clk, // Clock.
   input wire logic [2:0] tog, // Flip request: probe one, two, index.
   output logic probe1_in, // Probe pin one.
   output logic probe2_in, // Probe pin two.
   output logic index_in // Index pulse.
);
   timeunit 1ns;
   timeprecision 1ns;
   // Lines idle low; a requested line flips just after the edge.
   initial {probe1_in, probe2_in, index_in} = 3'h0;
   always @(posedge sys_clk) begin
      {index_in, probe2_in, probe1_in} <= {index_in, probe2_in, probe1_in} ^ tog;
   end
endmodule // tpc_probe_model
`default_nettype wire

// ### tb_touch_probe_capture_config.sv
// Self-checking bench for the probe capture block.
`default_nettype none
module tb_touch_probe_capture_config;
   timeunit 1ns;
   timeprecision 1ns;
   import tpc_pkg::*;
   logic sys_clk, rst, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, v, p;
   logic probe1_in, probe2_in, index_in, capture1, capture2, irq;
   logic [2:0] tog;
   int fails, tests_run, m;
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
   $display("BAD %s exp %0h got %0h", n, e, g); end end
   tpc_capture_top #(.CNT_W(16)) dut (.sys_clk, .rst, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .probe1_in, .probe2_in, .index_in, .capture1,
      .capture2, .irq);
   tpc_probe_model pm (.sys_clk, .tog, .probe1_in, .probe2_in, .index_in);
   // Clock of 100 ns period.
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // Bus write: hold the request until a rising edge sees waitrequest low.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Bus read: data are taken at the edge that sees waitrequest low.
   task automatic rd(input logic [3:0] a);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0);
      v = avs_readdata;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Flip the chosen far-side lines once, then let status settle.
   task automatic tg(input logic [2:0] t);
      tog <= t;
      @(posedge sys_clk);
      tog <= 3'h0;
      repeat (3) @(posedge sys_clk);
   endtask
   // Compare the capture status bits, then clear them.
   task automatic st(input logic [1:0] e);
      rd(TPC_ADDR_STATUS);
      `CHK("status", e, v[1:0])
      wr(TPC_ADDR_CLEAR, 32'h3);
   endtask
   // Print the counts and the verdict, then end the run.
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog against a hung handshake.
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      stop_test();
   end
   // Main test sequence.
   initial begin
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      rst = 1'b1;
      avs_byteenable = 4'hf;
      tog = 3'h0;
      fails = 0;
      tests_run = 0;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      for (m = 0; m < 9; m++) begin
         rd(m[3:0] | {m[3], 3'h0});
         if (m < 4 || m == 8) `CHK("reset", 32'h0, v)
      end
      wr(TPC_ADDR_EDGE, 32'hf);
      wr(TPC_ADDR_REPEAT, 32'h3);
      tg(3'h7);
      tg(3'h7);
      st(2'h0);
      avs_byteenable <= 4'h0;
      wr(TPC_ADDR_ENABLE, 32'h3);
      avs_byteenable <= 4'hf;
      rd(TPC_ADDR_ENABLE);
      `CHK("be0", 32'h0, v)
      for (m = 1; m < 4; m++) begin
         wr(TPC_ADDR_ENABLE, 32'(m));
         tg(3'h3);
         tg(3'h3);
         st(m[1:0]);
      end
      for (m = 0; m < 4; m++) begin
         wr(TPC_ADDR_SOURCE, 32'(m));
         tg(3'h4);
         tg(3'h4);
         st(m[1:0]);
         tg(3'h3);
         tg(3'h3);
         st(~m[1:0]);
      end
      wr(TPC_ADDR_SOURCE, 32'h0);
      for (m = 0; m < 16; m++) begin
         wr(TPC_ADDR_EDGE, 32'(m));
         tg(3'h3);
         st({m[2], m[0]});
         tg(3'h3);
         st({m[3], m[1]});
      end
      wr(TPC_ADDR_EDGE, 32'hf);
      for (m = 0; m < 4; m++) begin
         wr(TPC_ADDR_REPEAT, 32'(m));
         wr(TPC_ADDR_ENABLE, 32'h3);
         rd(TPC_ADDR_COUNT);
         p = v;
         tg(3'h3);
         tg(3'h3);
         rd(TPC_ADDR_COUNT);
         `CHK("count1", 16'(m[0] ? 2 : 1), 16'(v[15:0] - p[15:0]))
         `CHK("count2", 16'(m[1] ? 2 : 1), 16'(v[31:16] - p[31:16]))
         wr(TPC_ADDR_ENABLE, 32'h3);
         p = v;
         tg(3'h3);
         rd(TPC_ADDR_COUNT);
         `CHK("rearm", 32'h0001_0001, v - p)
         tg(3'h3);
      end
      wr(TPC_ADDR_CLEAR, 32'h3);
      wr(TPC_ADDR_IRQ_EN, 32'h1);
      `CHK("irq_pre", 1'b0, irq)
      tg(3'h1);
      `CHK("irq_set", 1'b1, irq)
      wr(TPC_ADDR_CLEAR, 32'h3);
      `CHK("irq_clr", 1'b0, irq)
      wr(TPC_ADDR_IRQ_EN, 32'h0);
      tg(3'h1);
      `CHK("irq_mask", 1'b0, irq)
      st(2'h1);
      stop_test();
   end
endmodule // tb_touch_probe_capture_config
`default_nettype wire
